// >>> bstp_map.vh
// Constants for the buck stage and thermal protection block.
// Assumes a 100 MHz ref_clk; analog comparisons arrive as digital levels.
`ifndef BSTP_MAP_VH
`define BSTP_MAP_VH
`define BSTP_CLK_MHZ 100
// Restart delay after overcurrent, in ms, and its cycle count
`define BSTP_RESTART_MS 1000
`define BSTP_RESTART_CYC (`BSTP_RESTART_MS * 1000 * `BSTP_CLK_MHZ)
// Thermal sample period in us and cycles
`define BSTP_SAMPLE_US 100
`define BSTP_SAMPLE_CYC (`BSTP_SAMPLE_US * `BSTP_CLK_MHZ)
// Slow derating filter time constant, s, and shift giving ~2 s at the sample rate
`define BSTP_SLOW_TC_S 2
`define BSTP_SLOW_SHIFT 14
`define BSTP_FAST_SHIFT 2
// Startup tracking limit in ms
`define BSTP_TRACK_MS 15
// Resistance codes: ohms / 16, pin held near 1.25 V reference
`define BSTP_CODE_95C 12'h4f5
`define BSTP_CODE_120C 12'h427
`define BSTP_CODE_125C 12'h40d
`define BSTP_DIM_MIN 10'h033
`define BSTP_DIM_MAX 10'h3ff
`endif

// >>> bstp_res_adc.v
// Resistance tracking loop for the external thermistor network.
// Assumes thermalPinHigh is a comparator of the pin against the reference.
`timescale 1ns/1ps
`include "bstp_map.vh"
module bstp_res_adc
(
  input wire ref_clk,
  input wire sys_rst,
  input wire sampleTick,
  input wire thermalPinHigh,
  output reg [11:0] resCode
);
  reg [3:0] sarIdx;
  reg sarDone;
  // ------------------------------------------------------------
  // Tracking step
  // ------------------------------------------------------------
  // Pin above reference means too much bias current: raise the resistance
  // code, which lowers the bias. A binary search comes first so a reading
  // is ready well inside the startup window; afterwards one LSB per sample
  // keeps the loop stable.
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      resCode <= 12'h800;
      sarIdx <= 4'hb;
      sarDone <= 1'b0;
    end
    else if (sampleTick)
    begin
      if (!sarDone)
      begin
        // Keep the trial bit while the pin says the code is still too low
        if (thermalPinHigh)
          resCode <= resCode | ((12'h001 << sarIdx) >> 1);
        else
          resCode <= (resCode & ~(12'h001 << sarIdx)) | ((12'h001 << sarIdx) >> 1);
        sarIdx <= sarIdx - 4'h1;
        sarDone <= (sarIdx == 4'h0);
      end
      else if (thermalPinHigh && resCode != 12'hfff)
        resCode <= resCode + 12'h001;
      else if (!thermalPinHigh && resCode != 12'h000)
        resCode <= resCode - 12'h001;
    end
  end
endmodule

// >>> bstp_buck_thermal.v
// Buck stage control with overcurrent, die and external thermal protection.
// Assumes comparator outputs synchronous to ref_clk; power-on reset on sys_rst.
// Notes on behaviour
// - Peak current ends each gate pulse
// - Measure demagnetization time from zero cross
// - Switching period sets next gate turn-on
// - LED current linear, monotonic, 5 to 100 percent
// - Overcurrent stops both gates, restarts after 1 s
// - Die overheating stops switching, with hysteresis
// - Thermistor resistance sampled periodically
// - Bias loop holds pin at reference
// - Fast filter compared against 125C code
// - Two-second filter derates dim above 95C
// - Derating ramps between 95C and 125C codes
// - Beyond 125C latch fault until power cycle
// - Startup waits for reading below 120C
// - Period averaged to reject line ripple
// - Dimmer control value sets current level
`timescale 1ns/1ps
`include "bstp_map.vh"
module bstp_buck_thermal
#(
  parameter RESTART_CYC = `BSTP_RESTART_CYC,
  parameter SAMPLE_CYC = `BSTP_SAMPLE_CYC,
  parameter TRACK_CYC = `BSTP_TRACK_MS * 1000 * `BSTP_CLK_MHZ
)
(
  input wire ref_clk,
  input wire sys_rst,
  input wire peakCurrentHit,
  input wire buckOvercurrent,
  input wire buckZeroCross,
  input wire dieOverTemp,
  input wire dieCooled,
  input wire thermalPinHigh,
  input wire [9:0] dimControl,
  output reg buckGateDrive,
  output reg boostGateDrive,
  output reg overcurrentFault,
  output reg dieThermalGuard,
  output reg externalThermalFault,
  output reg startupDone,
  output reg [9:0] dimLevel,
  output reg [11:0] resistanceCode,
  output reg [15:0] buckDemagPeriod,
  output reg [15:0] buckSwitchingPeriod
);
  localparam ST_OFF = 2'd0;
  localparam ST_ON = 2'd1;
  localparam ST_DEMAG = 2'd2;
  localparam ST_WAIT = 2'd3;

  wire [11:0] adcCode;
  reg [31:0] sampleCnt;
  reg sampleTick;
  reg [31:0] restartCnt;
  reg [31:0] trackCnt;
  reg [15:0] fastFilt;
  reg [25:0] slowFilt;
  reg [1:0] state;
  reg [15:0] phaseCnt;
  reg [15:0] onTime;
  reg [19:0] periodAvg;
  reg [9:0] derate;
  reg [9:0] next_dim;
  reg [31:0] derateWide;
  reg [19:0] dimProduct;

  // Saturating 16-bit increment, used for the switching phase counter phaseCnt
  function [15:0] sat_inc;
    input [15:0] v;
    begin
      sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
    end
  endfunction

  // ------------------------------------------------------------
  // Thermistor sampling
  // ------------------------------------------------------------
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sampleCnt <= 32'h0;
      sampleTick <= 1'b0;
    end
    else
    begin
      sampleTick <= (sampleCnt == SAMPLE_CYC - 1);
      sampleCnt <= (sampleCnt == SAMPLE_CYC - 1) ? 32'h0 : sampleCnt + 32'h1;
    end
  end

  bstp_res_adc u_adc
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sampleTick(sampleTick),
    .thermalPinHigh(thermalPinHigh),
    .resCode(adcCode)
  );

  // ------------------------------------------------------------
  // Filters and thermal decisions
  // ------------------------------------------------------------
  // The fast filter is a short average for noise; the slow one a long IIR
  // so derating never shows as a visible step.
  wire extHot = startupDone && fastFilt[15:4] < `BSTP_CODE_125C;

  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fastFilt <= 16'hffff;
      slowFilt <= 26'h3ffffff;
      externalThermalFault <= 1'b0;
      startupDone <= 1'b0;
      trackCnt <= 32'h0;
      resistanceCode <= 12'h000;
    end
    else
    begin
      resistanceCode <= adcCode;
      if (sampleTick)
      begin
        fastFilt <= fastFilt - (fastFilt >> `BSTP_FAST_SHIFT)
          + {2'b00, adcCode, 2'b00};
        slowFilt <= slowFilt - (slowFilt >> `BSTP_SLOW_SHIFT)
          + {14'h0000, adcCode};
      end
      if (extHot)
        externalThermalFault <= 1'b1;
      if (trackCnt < TRACK_CYC)
        trackCnt <= trackCnt + 32'h1;
      // Startup trusts the raw code once the fast tracking window has passed
      if (!startupDone && trackCnt >= TRACK_CYC && adcCode > `BSTP_CODE_120C)
        startupDone <= 1'b1;
    end
  end

  // Derate from full at the 95C code to minimum at the 125C code
  always @*
  begin
    derateWide = ({20'h00000, slowFilt[25:14]} - {20'h00000, `BSTP_CODE_125C})
      * 32'h000003ff / ({20'h00000, `BSTP_CODE_95C} - {20'h00000, `BSTP_CODE_125C});
    if (slowFilt[25:14] >= `BSTP_CODE_95C)
      derate = 10'h3ff;
    else if (slowFilt[25:14] <= `BSTP_CODE_125C)
      derate = 10'h000;
    else
      derate = derateWide[9:0];
    dimProduct = {10'h000, dimControl} * {10'h000, derate};
    next_dim = dimProduct[19:10];
    if (next_dim < `BSTP_DIM_MIN)
      next_dim = `BSTP_DIM_MIN;
  end

  // ------------------------------------------------------------
  // Faults
  // ------------------------------------------------------------
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      overcurrentFault <= 1'b0;
      restartCnt <= 32'h0;
      dieThermalGuard <= 1'b0;
      dimLevel <= `BSTP_DIM_MIN;
    end
    else
    begin
      dimLevel <= next_dim;
      if (buckOvercurrent)
      begin
        overcurrentFault <= 1'b1;
        restartCnt <= 32'h0;
      end
      else if (overcurrentFault)
      begin
        if (restartCnt == RESTART_CYC - 1)
          overcurrentFault <= 1'b0;
        else
          restartCnt <= restartCnt + 32'h1;
      end
      if (dieOverTemp)
        dieThermalGuard <= 1'b1;
      else if (dieCooled)
        dieThermalGuard <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Buck switching cycle
  // ------------------------------------------------------------
  // Raw triggers are included so the gates drop on the same edge as the flag
  wire runOk = startupDone && !overcurrentFault && !dieThermalGuard
    && !externalThermalFault && !buckOvercurrent && !dieOverTemp && !extHot;
  // Off time scaled by the dim level; saturates rather than wrapping on a long cycle
  wire [31:0] periodRaw = ({16'h0000, onTime} + {16'h0000, phaseCnt}) * 32'h000003ff
    / ({22'h000000, dimLevel} + 32'h00000001);
  wire [15:0] periodStep = (periodRaw[31:16] != 16'h0000) ? 16'hffff : periodRaw[15:0];

  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= ST_OFF;
      phaseCnt <= 16'h0;
      onTime <= 16'h0;
      periodAvg <= 20'h0;
      buckDemagPeriod <= 16'h0;
      buckSwitchingPeriod <= 16'h0;
      buckGateDrive <= 1'b0;
      boostGateDrive <= 1'b0;
    end
    else if (!runOk)
    begin
      state <= ST_OFF;
      buckGateDrive <= 1'b0;
      boostGateDrive <= 1'b0;
    end
    else
    begin
      boostGateDrive <= 1'b1;
      phaseCnt <= sat_inc(phaseCnt);
      case (state)
        ST_OFF:
        begin
          state <= ST_ON;
          buckGateDrive <= 1'b1;
          phaseCnt <= 16'h0;
        end
        ST_ON:
          if (peakCurrentHit)
          begin
            buckGateDrive <= 1'b0;
            onTime <= phaseCnt;
            phaseCnt <= 16'h0;
            state <= ST_DEMAG;
          end
        ST_DEMAG:
          if (buckZeroCross)
          begin
            buckDemagPeriod <= phaseCnt;
            // Off time scales inversely with dim level: total period grows
            // as current falls, giving a linear current law.
            periodAvg <= periodAvg - (periodAvg >> 4)
              + {4'h0, periodStep};
            phaseCnt <= sat_inc(phaseCnt);
            state <= ST_WAIT;
          end
        ST_WAIT:
        begin
          buckSwitchingPeriod <= periodAvg[19:4];
          if ({16'h0, onTime} + {16'h0, phaseCnt} >= {16'h0, periodAvg[19:4]})
          begin
            buckGateDrive <= 1'b1;
            phaseCnt <= 16'h0;
            state <= ST_ON;
          end
        end
        default:
          state <= ST_OFF;
      endcase
    end
  end
endmodule

// >>> bstp_power_stage.sv
// Behavioural buck power stage and thermistor network.
// Assumes gate and loop code come from the block; updates at the falling edge.
`timescale 1ns/1ps
module bstp_power_stage
(
  input wire ref_clk,
  input wire buckGateDrive,
  input wire [11:0] resistanceCode,
  input wire [11:0] targetCode,
  output reg peakCurrentHit,
  output reg buckZeroCross,
  output reg thermalPinHigh
);
  reg [3:0] onCount = 4'h0;
  reg [3:0] offCount = 4'h0;
  initial {peakCurrentHit, buckZeroCross, thermalPinHigh} = 3'b000;
  always @(negedge ref_clk)
  begin
    onCount <= buckGateDrive ? onCount + 4'h1 : 4'h0;
    offCount <= buckGateDrive ? 4'h0 : offCount + {3'h0, offCount != 4'hf};
    // Inductor reaches the peak after six cycles of gate on
    peakCurrentHit <= buckGateDrive && onCount >= 4'h5;
    // Current is back at zero five cycles after turn-off
    buckZeroCross <= !buckGateDrive && offCount >= 4'h4;
    // Pin sits above reference while the code is below the network value
    thermalPinHigh <= resistanceCode < targetCode;
  end
endmodule

// >>> bstp_buck_thermal_assertions.sv
// Protocol checker for the buck and thermal protection block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module bstp_buck_thermal_assertions
(
  input wire ref_clk,
  input wire sys_rst,
  input wire peakCurrentHit,
  input wire buckOvercurrent,
  input wire dieOverTemp,
  input wire buckGateDrive,
  input wire boostGateDrive,
  input wire overcurrentFault,
  input wire dieThermalGuard,
  input wire externalThermalFault,
  input wire startupDone,
  input wire [9:0] dimLevel
);
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_peak_ends_pulse: assert property (peakCurrentHit |=> !buckGateDrive)
    else $error("gate still on after peak");
  a_ocp_stops_gates: assert property (buckOvercurrent |=> overcurrentFault
    && !buckGateDrive && !boostGateDrive)
    else $error("overcurrent did not stop gates");
  a_ocp_wait_holds: assert property ($rose(overcurrentFault) |-> overcurrentFault[*8])
    else $error("restart wait too short");
  a_die_guard_entry: assert property (dieOverTemp |=> dieThermalGuard)
    else $error("die guard not set");
  a_die_no_switch: assert property (dieThermalGuard |-> !buckGateDrive)
    else $error("switching during die guard");
  a_ext_fault_latch: assert property (externalThermalFault |=> externalThermalFault)
    else $error("thermal fault released");
  a_ext_no_switch: assert property (externalThermalFault |-> !buckGateDrive
    && !boostGateDrive)
    else $error("switching during thermal fault");
  a_startup_gate_off: assert property (!startupDone |-> !buckGateDrive)
    else $error("switching before startup");
  a_dim_floor_kept: assert property (dimLevel >= 10'h033)
    else $error("dim level below floor");
  c_ocp: cover property ($rose(overcurrentFault));
  c_die: cover property ($rose(dieThermalGuard));
  c_ext: cover property ($rose(externalThermalFault));
endmodule
bind bstp_buck_thermal bstp_buck_thermal_assertions u_chk (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .peakCurrentHit(peakCurrentHit), .buckOvercurrent(buckOvercurrent),
  .dieOverTemp(dieOverTemp), .buckGateDrive(buckGateDrive), .boostGateDrive(boostGateDrive),
  .overcurrentFault(overcurrentFault), .dieThermalGuard(dieThermalGuard),
  .externalThermalFault(externalThermalFault), .startupDone(startupDone),
  .dimLevel(dimLevel));

// >>> bstp_buck_thermal_bench.sv
// Self-checking bench for the buck and thermal protection block.
// Assumes short counts: restart 100, sample 4, track 50 cycles.
`timescale 1ns/1ps
module bstp_buck_thermal_bench;
  reg ref_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg buckOvercurrent = 1'b0;
  reg dieOverTemp = 1'b0;
  reg dieCooled = 1'b0;
  reg [9:0] dimControl = 10'h200;
  reg [11:0] targetCode = 12'h400;
  integer failures = 0;
  integer num_checks = 0;
  integer n;
  wire peakCurrentHit, buckZeroCross, thermalPinHigh, buckGateDrive, boostGateDrive;
  wire overcurrentFault, dieThermalGuard, externalThermalFault, startupDone;
  wire [9:0] dimLevel;
  wire [11:0] resistanceCode;
  wire [15:0] buckDemagPeriod, buckSwitchingPeriod;
  always #5 ref_clk = ~ref_clk;
  bstp_buck_thermal #(.RESTART_CYC(100), .SAMPLE_CYC(4), .TRACK_CYC(50)) u_bstp_buck_thermal (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .peakCurrentHit(peakCurrentHit),
    .buckOvercurrent(buckOvercurrent), .buckZeroCross(buckZeroCross),
    .dieOverTemp(dieOverTemp), .dieCooled(dieCooled), .thermalPinHigh(thermalPinHigh),
    .dimControl(dimControl), .buckGateDrive(buckGateDrive), .boostGateDrive(boostGateDrive),
    .overcurrentFault(overcurrentFault), .dieThermalGuard(dieThermalGuard),
    .externalThermalFault(externalThermalFault), .startupDone(startupDone),
    .dimLevel(dimLevel), .resistanceCode(resistanceCode), .buckDemagPeriod(buckDemagPeriod),
    .buckSwitchingPeriod(buckSwitchingPeriod));
  bstp_power_stage u_bstp_power_stage (.ref_clk(ref_clk), .buckGateDrive(buckGateDrive),
    .resistanceCode(resistanceCode), .targetCode(targetCode),
    .peakCurrentHit(peakCurrentHit), .buckZeroCross(buckZeroCross),
    .thermalPinHigh(thermalPinHigh));
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task check(input string what, input [15:0] exp, input [15:0] got);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  task tally_and_finish;
  begin
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task step(input integer k);
    repeat (k) @(negedge ref_clk);
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task t_startup;
  begin
    step(300);
    check("code tracked", 16'h1, {15'h0, resistanceCode >= 12'h3fe &&
      resistanceCode <= 12'h402});
    check("startupDone hot", 16'h0, {15'h0, startupDone});
    check("fault before startup", 16'h0, {15'h0, externalThermalFault});
    targetCode = 12'h600;
    for (n = 0; n < 20000 && startupDone !== 1'b1; n = n + 1) step(1);
    check("startupDone cool", 16'h1, {15'h0, startupDone});
  end
  endtask
  task t_peak;
  begin
    for (n = 0; n < 500 && peakCurrentHit !== 1'b1; n = n + 1) step(1);
    step(1);
    check("gate after peak", 16'h0, {15'h0, buckGateDrive});
    step(40);
    check("demag in range", 16'h1, {15'h0, buckDemagPeriod >= 16'h4 &&
      buckDemagPeriod <= 16'h7});
    check("next pulse", 16'h1, {15'h0, buckSwitchingPeriod != 16'h0});
    check("dimLevel cool", 16'h01ff, {6'h0, dimLevel});
  end
  endtask
  task t_ocp;
  begin
    buckOvercurrent = 1'b1;
    step(1);
    buckOvercurrent = 1'b0;
    check("ocp gates", 16'h4, {13'h0, overcurrentFault, boostGateDrive, buckGateDrive});
    step(50);
    buckOvercurrent = 1'b1;
    step(1);
    buckOvercurrent = 1'b0;
    step(80);
    check("restart cleared", 16'h1, {15'h0, overcurrentFault});
    step(40);
    check("restarted", 16'h0, {15'h0, overcurrentFault});
  end
  endtask
  task t_die;
  begin
    dieOverTemp = 1'b1;
    step(3);
    dieOverTemp = 1'b0;
    step(20);
    check("die hysteresis", 16'h2, {14'h0, dieThermalGuard, buckGateDrive});
    dieCooled = 1'b1;
    step(3);
    check("die resumed", 16'h0, {15'h0, dieThermalGuard});
  end
  endtask
  task t_ext;
  begin
    targetCode = 12'h400;
    for (n = 0; n < 20000 && externalThermalFault !== 1'b1; n = n + 1) step(1);
    check("ext fault", 16'h1, {15'h0, externalThermalFault});
    targetCode = 12'h600;
    step(5000);
    check("ext latched", 16'h2, {14'h0, externalThermalFault, buckGateDrive});
  end
  endtask
  initial
  begin
    step(10);
    sys_rst = 1'b0;
    t_startup;
    t_peak;
    t_ocp;
    t_die;
    t_ext;
    tally_and_finish;
  end
  // Generous bound: the longest run is about 6k cycles
  initial
  begin
    #1000000;
    failures = failures + 1;
    tally_and_finish;
  end
endmodule
